// >>> host_model.sv
`timescale 1ns/1ps
// host side of the register port; every word goes out whole
module host_model
    import pin_ctrl_pkg::*;
(
    input  wire logic        clk,
    output logic             wrValid,
    output logic [15:0]      wrWord,
    output logic             rdReq,
    output logic [4:0]       rdAddr,
    input  wire logic        rdAck,
    input  wire logic [7:0]  rdData
);
    // idle lines show inverted values so stale words never look valid
    initial begin
        wrValid = 1'b0;
        wrWord  = 16'h0000;
        rdReq   = 1'b0;
        rdAddr  = 5'h00;
    end
    task automatic put(input logic [15:0] word);
        @(posedge clk);
        wrValid <= 1'b1;
        wrWord  <= word;
        @(posedge clk);
        wrValid <= 1'b0;
        wrWord  <= ~word;
    endtask : put
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        put({WR_EXT_PREFIX, addr, data});
    endtask : wr
    // answer is taken at the rising edge where the one-cycle ack stands
    task automatic get(input logic [4:0] addr, output logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk);
        rdReq  <= 1'b1;
        rdAddr <= addr;
        @(posedge clk);
        rdReq  <= 1'b0;
        rdAddr <= ~addr;
        @(posedge clk);
        while (rdAck !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        data = (rdAck === 1'b1) ? rdData : 8'hXX;
        // hand back mid-cycle so callers never look at pins on an edge
        @(negedge clk);
    endtask : get
endmodule : host_model

// >>> pin_ctrl_pkg.sv
package pin_ctrl_pkg;
    // extended write word: [15:12] prefix, [11:8] register, [7:0] data
    localparam logic [3:0] WR_EXT_PREFIX      = 4'hF;
    localparam int         WR_PREFIX_MSB      = 15;
    localparam int         WR_PREFIX_LSB      = 12;
    localparam int         WR_ADDR_MSB        = 11;
    localparam int         WR_ADDR_LSB        = 8;
    localparam int         WR_DATA_MSB        = 7;
    localparam logic [3:0] WR_ADDR_CTRL_UPPER = 4'h1;
    localparam logic [3:0] WR_ADDR_PIN_DATA   = 4'h2;

    // read addresses
    localparam logic [4:0] RD_ADDR_CTRL_UPPER = 5'h1C;
    localparam logic [4:0] RD_ADDR_PIN_DATA   = 5'h1D;

    // pin_control_upper fields
    localparam int PIN4_ALERT_ENABLE    = 0;
    localparam int PIN4_DIRECTION       = 1;
    localparam int PIN4_POLARITY        = 2;
    localparam int PIN3_ALERT_ENABLE    = 4;
    localparam int PIN3_DIRECTION       = 5;
    localparam int PIN3_POLARITY        = 6;
    localparam int PIN3_FUNCTION_SELECT = 7;

    // pin_data fields
    localparam int PIN4_DATA_BIT = 4;
    localparam int PIN3_DATA_BIT = 5;
    localparam int PIN2_DATA_BIT = 6;
    localparam int PIN1_DATA_BIT = 7;

    // implemented bits and reset values
    localparam logic [7:0] CTRL_UPPER_MASK  = 8'hF7;
    localparam logic [7:0] PIN_DATA_MASK    = 8'hF0;
    localparam logic [7:0] CTRL_UPPER_RESET = 8'h00;
    localparam logic [7:0] PIN_DATA_RESET   = 8'h00;
endpackage : pin_ctrl_pkg

// >>> tb_touch_adc_gpio_upper_control.sv
`timescale 1ns/1ps
module tb_touch_adc_gpio_upper_control;
    import pin_ctrl_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pin3In = 1'b1;
    logic        pin4In = 1'b1;
    logic        wrValid, rdReq, rdAck, pin3Out, pin3Oe, pin4Out, pin4Oe;
    logic        pin3IsDigital, pin1DataBit, pin2DataBit, alertOut;
    logic [15:0] wrWord;
    logic [4:0]  rdAddr;
    logic [7:0]  rdData;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    touch_adc_gpio_upper_control u_touch_adc_gpio_upper_control (.clk, .rst, .wrValid,
        .wrWord, .rdReq, .rdAddr, .rdAck, .rdData, .pin3In, .pin3Out, .pin3Oe, .pin4In,
        .pin4Out, .pin4Oe, .pin3IsDigital, .pin1DataBit, .pin2DataBit, .alertOut);
    host_model u_host_model (.clk, .wrValid, .wrWord, .rdReq, .rdAddr, .rdAck, .rdData);
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host_model.get(addr, d);
        chk(d, exp);
    endtask : rd
    // pin outputs lag the register, alert lags two cycles; three falling edges are the fewest that see it
    task automatic wt();
        repeat (3) @(negedge clk);
    endtask : wt
    function automatic logic [7:0] pins();
        return {4'h0, pin4Oe, pin4Out, pin3Oe, pin3Out};
    endfunction : pins
    // a hang is cut short well past the fewer than a hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wt();
        rd(RD_ADDR_CTRL_UPPER, CTRL_UPPER_RESET);
        rd(RD_ADDR_PIN_DATA, PIN_DATA_RESET);
        chk(pins(), 8'h0D);
        chk({6'h00, alertOut, pin3IsDigital}, 8'h00);
        $display("test reset done");
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'h80);
        u_host_model.wr(WR_ADDR_PIN_DATA, 8'hFF);
        wt();
        rd(RD_ADDR_PIN_DATA, 8'hF0);
        chk(pins(), 8'h0A);
        chk({5'h00, pin1DataBit, pin2DataBit, pin3IsDigital}, 8'h07);
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'hC4);
        wt();
        chk(pins(), 8'h0F);
        rd(RD_ADDR_CTRL_UPPER, 8'hC4);
        $display("test outputs done");
        u_host_model.put(16'hE1FF);
        u_host_model.put(16'hF3FF);
        rd(RD_ADDR_CTRL_UPPER, 8'hC4);
        rd(5'h1B, 8'h00);
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'hFF);
        rd(RD_ADDR_CTRL_UPPER, 8'hF7);
        $display("test access done");
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'hB3);
        wt();
        chk({5'h00, pin4Oe, pin3Oe, alertOut}, 8'h00);
        rd(RD_ADDR_PIN_DATA, 8'hC0);
        @(posedge clk) pin4In <= 1'b0;
        wt();
        chk({7'h00, alertOut}, 8'h01);
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'hB2);
        wt();
        chk({7'h00, alertOut}, 8'h00);
        @(posedge clk) pin3In <= 1'b0;
        wt();
        chk({7'h00, alertOut}, 8'h01);
        rd(RD_ADDR_PIN_DATA, 8'hF0);
        $display("test alerts done");
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'hF6);
        wt();
        rd(RD_ADDR_PIN_DATA, 8'hC0);
        chk({7'h00, alertOut}, 8'h00);
        u_host_model.wr(WR_ADDR_CTRL_UPPER, 8'h32);
        wt();
        chk({5'h00, alertOut, pin3IsDigital, pin3Oe}, 8'h00);
        $display("test modes done");
        summarize();
    end
endmodule : tb_touch_adc_gpio_upper_control

// >>> touch_adc_gpio_upper_control.sv
`timescale 1ns/1ps
module touch_adc_gpio_upper_control
    import pin_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wrValid,
    input  wire logic [15:0] wrWord,
    input  wire logic        rdReq,
    input  wire logic [4:0]  rdAddr,
    output logic             rdAck,
    output logic [7:0]       rdData,
    input  wire logic        pin3In,
    output logic             pin3Out,
    output logic             pin3Oe,
    input  wire logic        pin4In,
    output logic             pin4Out,
    output logic             pin4Oe,
    output logic             pin3IsDigital,
    output logic             pin1DataBit,
    output logic             pin2DataBit,
    output logic             alertOut
);

    logic [7:0] ctrl_ff;
    logic [7:0] data_ff;
    logic [7:0] nxt_data;
    logic       rdAck_ff;
    logic [7:0] rdData_ff;
    logic       pin3Out_ff;
    logic       pin3Oe_ff;
    logic       pin4Out_ff;
    logic       pin4Oe_ff;
    logic       alert_ff;
    logic       extWrite;
    logic       wrCtrl;
    logic       wrData;
    logic       pin3Digital;
    logic       pin3Input;
    logic       pin4Input;
    logic       pin3Alert;
    logic       pin4Alert;

    // level seen by the pin for a data bit, after polarity
    function automatic logic applyPolarity(input logic value, input logic activeHigh);
        applyPolarity = activeHigh ? value : ~value;
    endfunction : applyPolarity

    // only words carrying the extended prefix reach these registers
    assign extWrite = wrValid
                    && (wrWord[WR_PREFIX_MSB:WR_PREFIX_LSB] == WR_EXT_PREFIX);
    assign wrCtrl   = extWrite && (wrWord[WR_ADDR_MSB:WR_ADDR_LSB] == WR_ADDR_CTRL_UPPER);
    assign wrData   = extWrite && (wrWord[WR_ADDR_MSB:WR_ADDR_LSB] == WR_ADDR_PIN_DATA);

    // pin modes decoded from the control register
    assign pin3Digital = ctrl_ff[PIN3_FUNCTION_SELECT];
    assign pin3Input   = pin3Digital && ctrl_ff[PIN3_DIRECTION];
    assign pin4Input   = ctrl_ff[PIN4_DIRECTION];

    // control register; unused bit 3 never stores
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_UPPER_RESET;
        end else if (wrCtrl) begin
            ctrl_ff <= wrWord[WR_DATA_MSB:0] & CTRL_UPPER_MASK;
        end
    end

    // data register: inputs own their bit, so host writes to it are dropped
    always_comb begin
        nxt_data = data_ff;
        if (wrData) begin
            nxt_data = wrWord[WR_DATA_MSB:0];
        end
        if (pin4Input) begin
            nxt_data[PIN4_DATA_BIT] = applyPolarity(pin4In, ctrl_ff[PIN4_POLARITY]);
        end
        if (pin3Input) begin
            nxt_data[PIN3_DATA_BIT] = applyPolarity(pin3In, ctrl_ff[PIN3_POLARITY]);
        end
        nxt_data = nxt_data & PIN_DATA_MASK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_ff <= PIN_DATA_RESET;
        end else begin
            data_ff <= nxt_data;
        end
    end

    // pin drivers; analog mode keeps pin three undriven
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin3Out_ff <= 1'b0;
            pin3Oe_ff  <= 1'b0;
            pin4Out_ff <= 1'b0;
            pin4Oe_ff  <= 1'b0;
        end else begin
            pin4Oe_ff  <= ~pin4Input;
            pin4Out_ff <= applyPolarity(data_ff[PIN4_DATA_BIT], ctrl_ff[PIN4_POLARITY]);
            pin3Oe_ff  <= pin3Digital && ~ctrl_ff[PIN3_DIRECTION];
            pin3Out_ff <= applyPolarity(data_ff[PIN3_DATA_BIT], ctrl_ff[PIN3_POLARITY]);
        end
    end

    // alert sources: enabled inputs whose data bit shows the active level
    assign pin4Alert = ctrl_ff[PIN4_ALERT_ENABLE] && pin4Input && data_ff[PIN4_DATA_BIT];
    assign pin3Alert = ctrl_ff[PIN3_ALERT_ENABLE] && pin3Input && data_ff[PIN3_DATA_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_ff <= 1'b0;
        end else begin
            alert_ff <= pin4Alert || pin3Alert;
        end
    end

    // read port, one cycle latency; unmapped addresses answer zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdAck_ff  <= 1'b0;
            rdData_ff <= 8'h00;
        end else begin
            rdAck_ff <= rdReq;
            if (rdReq) begin
                case (rdAddr)
                    RD_ADDR_CTRL_UPPER: rdData_ff <= ctrl_ff;
                    RD_ADDR_PIN_DATA:   rdData_ff <= data_ff;
                    default:            rdData_ff <= 8'h00;
                endcase
            end
        end
    end

    assign rdAck         = rdAck_ff;
    assign rdData        = rdData_ff;
    assign pin3Out       = pin3Out_ff;
    assign pin3Oe        = pin3Oe_ff;
    assign pin4Out       = pin4Out_ff;
    assign pin4Oe        = pin4Oe_ff;
    assign pin3IsDigital = ctrl_ff[PIN3_FUNCTION_SELECT];
    assign pin1DataBit   = data_ff[PIN1_DATA_BIT];
    assign pin2DataBit   = data_ff[PIN2_DATA_BIT];
    assign alertOut      = alert_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_pin4_alert_mask: assert property (
        (!ctrl_ff[PIN4_ALERT_ENABLE] && !pin3Alert) |=> !alertOut)
        else $error("alert raised while pin four masked");

    a_pin4_dir_output: assert property (
        !ctrl_ff[PIN4_DIRECTION] |=> pin4Oe)
        else $error("pin four not driven as output");

    a_pin4_pol_drive: assert property (
        !ctrl_ff[PIN4_DIRECTION] |=>
            pin4Out == ($past(data_ff[PIN4_DATA_BIT]) ~^ $past(ctrl_ff[PIN4_POLARITY])))
        else $error("pin four level wrong for polarity");

    a_pin3_alert_mask: assert property (
        (!ctrl_ff[PIN3_ALERT_ENABLE] && !pin4Alert) |=> !alertOut)
        else $error("alert raised while pin three masked");

    a_pin3_dir_io: assert property (
        pin3Digital |=> (pin3Oe == !$past(ctrl_ff[PIN3_DIRECTION])))
        else $error("pin three enable disagrees with direction");

    a_pin3_pol_drive: assert property (
        (pin3Digital && !ctrl_ff[PIN3_DIRECTION]) |=>
            pin3Out == ($past(data_ff[PIN3_DATA_BIT]) ~^ $past(ctrl_ff[PIN3_POLARITY])))
        else $error("pin three level wrong for polarity");

    a_analog_undriven: assert property (
        !pin3Digital [*2] |-> !pin3Oe)
        else $error("pin three driven in analog mode");

    a_data_write: assert property (
        (wrData && !pin4Input) |=>
            (data_ff[PIN4_DATA_BIT] == $past(wrWord[PIN4_DATA_BIT]))
            && (data_ff[3:0] == 4'h0)
            && (pin1DataBit == $past(wrWord[PIN1_DATA_BIT])))
        else $error("pin data write not stored");

    a_input_sample: assert property (
        pin4Input |=> data_ff[PIN4_DATA_BIT] == ($past(pin4In) ~^ $past(ctrl_ff[PIN4_POLARITY])))
        else $error("pin four input not sampled");

    a_alert_raise: assert property (
        (pin4Input && ctrl_ff[PIN4_ALERT_ENABLE] && pin4In == ctrl_ff[PIN4_POLARITY]
            && !wrCtrl) |-> ##2 alertOut)
        else $error("alert not raised for active input");

    // analog mode must keep pin three out of the alert even if its data bit is set
    a_analog_no_alert: assert property (
        (!pin3Digital && !pin4Alert) |=> !alertOut)
        else $error("alert raised by pin three in analog mode");

    // readback shows the stored data byte, unused low bits included
    a_data_readback: assert property (
        (rdReq && rdAddr == RD_ADDR_PIN_DATA) |=> (rdAck && rdData == $past(data_ff)))
        else $error("pin data readback wrong");

    c_alert_pin4: cover property (pin4Alert ##1 alertOut);
    c_alert_pin3: cover property (pin3Alert ##1 alertOut);
    c_pin3_output: cover property (pin3Oe && pin3Out);
    c_read_data: cover property (rdReq && rdAddr == RD_ADDR_PIN_DATA ##1 rdAck);
    c_pin3_to_digital: cover property (!pin3IsDigital ##1 pin3IsDigital);

endmodule : touch_adc_gpio_upper_control

// >>> touch_adc_gpio_upper_control_note_end.sv
`timescale 1ns/1ps
